// File: include/lsp_params.svh
// constants of the led driver serial shift port
`ifndef LSP_PARAMS_SVH
`define LSP_PARAMS_SVH
`define LSP_SHIFT_BITS 257
`define LSP_FLAG_COUNT 5
`define LSP_REG_STATUS 8'h00
`define LSP_REG_MASK 8'h04
`define LSP_REG_CAPTURE 8'h08
`define LSP_REG_SHIFT_COUNT 8'h0C
`define LSP_REG_FLAGS 8'h10
`define LSP_EV_SHIFT 0
`define LSP_EV_LATCH 1
`define LSP_EV_FRAME 2
`define LSP_EV_WIDTH 3
`endif

// File: include/lsp_pkg.sv
// types of the led driver serial shift port
package lsp_pkg;
    typedef logic [31:0] lsp_word_t;
    typedef logic [2:0] lsp_event_t;
endpackage : lsp_pkg

// File: src/lsp_serial_port.sv
// led driver serial shift port with avalon register slave
`timescale 1ns/1ps
`include "lsp_params.svh"
module lsp_serial_port import lsp_pkg::*; #(
    parameter int SHIFT_BITS = `LSP_SHIFT_BITS
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic latch_pulse,
    input wire logic led_open_flag,
    input wire logic led_short_flag,
    input wire logic output_leakage_flag,
    input wire logic thermal_error_flag,
    input wire logic reference_pin_short_flag,
    output logic serial_out,
    output logic irq,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    // link clock runs far slower than mclk, so sampling it and finding edges is safe
    logic sclk_sync;
    logic sin_sync;
    logic lat_sync;
    logic [`LSP_FLAG_COUNT-1:0] flg_pins;
    logic [`LSP_FLAG_COUNT-1:0] flg_sync;
    logic sclk_prev_reg;
    logic lat_prev_reg;

    assign flg_pins = {reference_pin_short_flag, thermal_error_flag,
        output_leakage_flag, led_short_flag,
        led_open_flag};

    lsp_sync2 #(
        .WIDTH(1)
    ) u_sclk_sync (
        .mclk(mclk),
        .nrst(nrst),
        .d(shift_clk),
        .q(sclk_sync)
    );

    lsp_sync2 #(
        .WIDTH(1)
    ) u_sin_sync (
        .mclk(mclk),
        .nrst(nrst),
        .d(serial_in),
        .q(sin_sync)
    );

    lsp_sync2 #(
        .WIDTH(1)
    ) u_lat_sync (
        .mclk(mclk),
        .nrst(nrst),
        .d(latch_pulse),
        .q(lat_sync)
    );

    lsp_sync2 #(
        .WIDTH(`LSP_FLAG_COUNT)
    ) u_flg_sync (
        .mclk(mclk),
        .nrst(nrst),
        .d(flg_pins),
        .q(flg_sync)
    );

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_sync;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lat_prev_reg <= 1'b0;
        end else begin
            lat_prev_reg <= lat_sync;
        end
    end

    wire sclk_rise = sclk_sync & ~sclk_prev_reg;
    wire lat_rise = lat_sync & ~lat_prev_reg;

    // ****************************************
    // common shift register
    // ****************************************
    // serial input is sampled with the same two-stage delay as the clock, so
    // the bit taken is the one present at the shift clock edge
    logic [SHIFT_BITS-1:0] shift_reg;
    logic [SHIFT_BITS-1:0] shift_next;
    logic serial_out_reg;
    logic serial_out_next;

    wire [SHIFT_BITS-1:0] status_info_data = {{(SHIFT_BITS-`LSP_FLAG_COUNT){1'b0}}, flg_sync};
    wire [SHIFT_BITS-1:0] shifted = {shift_reg[SHIFT_BITS-2:0], sin_sync};

    always_comb begin
        shift_next = shift_reg;
        if (sclk_rise) begin
            shift_next = shifted;
        end else if (lat_rise) begin
            shift_next = status_info_data;
        end
    end

    assign serial_out_next = sclk_rise ? shift_reg[SHIFT_BITS-2] : serial_out_reg;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= shift_next;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            serial_out_reg <= 1'b0;
        end else begin
            serial_out_reg <= serial_out_next;
        end
    end

    assign serial_out = serial_out_reg;

    // ****************************************
    // frame counter
    // ****************************************
    // shift count since last latch or full frame; reaching a full frame flags an event and restarts the count at zero
    logic [8:0] count_reg;
    logic [8:0] count_next;

    wire frame_done = sclk_rise && (count_reg == 9'(SHIFT_BITS - 1));

    always_comb begin
        count_next = count_reg;
        if (lat_rise) begin
            count_next = 9'h000;
        end else if (frame_done) begin
            count_next = 9'h000;
        end else if (sclk_rise) begin
            count_next = count_reg + 9'h001;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 9'h000;
        end else begin
            count_reg <= count_next;
        end
    end

    // ****************************************
    // register slave and interrupt
    // ****************************************
    logic [`LSP_EV_WIDTH-1:0] status_reg;
    logic [`LSP_EV_WIDTH-1:0] mask_reg;
    logic [`LSP_FLAG_COUNT-1:0] capture_reg;
    logic [31:0] rdata_reg;
    logic wait_reg;
    logic irq_reg;

    wire [`LSP_EV_WIDTH-1:0] ev_set = {frame_done, lat_rise, sclk_rise};
    wire req = (avs_read | avs_write) & wait_reg;
    wire rd_take = req & avs_read;

    wire wr_ok = avs_write & ~wait_reg;

    wire sel_status = avs_address == `LSP_REG_STATUS;
    wire sel_mask = avs_address == `LSP_REG_MASK;
    wire sel_capture = avs_address == `LSP_REG_CAPTURE;
    wire sel_count = avs_address == `LSP_REG_SHIFT_COUNT;
    wire sel_flags = avs_address == `LSP_REG_FLAGS;

    wire wr_status = wr_ok & sel_status & avs_byteenable[0];
    wire wr_mask = wr_ok & sel_mask & avs_byteenable[0];
    wire [`LSP_EV_WIDTH-1:0] status_clr = wr_status ? avs_writedata[2:0] : 3'h0;
    // set wins over a clear in the same cycle, so no event is lost
    wire [`LSP_EV_WIDTH-1:0] status_next = (status_reg & ~status_clr) | ev_set;

    wire [31:0] rd_status = {29'h0000_0000, status_reg};
    wire [31:0] rd_mask = {29'h0000_0000, mask_reg};
    wire [31:0] rd_capture = {27'h000_0000, capture_reg};
    wire [31:0] rd_count = {23'h00_0000, count_reg};
    wire [31:0] rd_flags = {27'h000_0000, flg_sync};

    wire [31:0] rd_mux =
        sel_status ? rd_status :
        sel_mask ? rd_mask :
        sel_capture ? rd_capture :
        sel_count ? rd_count :
        sel_flags ? rd_flags : 32'h0000_0000;

    // one wait cycle per access keeps read data registered
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~req;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (rd_take) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status_reg <= 3'h0;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mask_reg <= 3'h0;
        end else begin
            if (wr_mask) begin
                mask_reg <= avs_writedata[2:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            capture_reg <= 5'h00;
        end else begin
            if (lat_rise) begin
                capture_reg <= flg_sync;
            end
        end
    end

    // next status is used so the interrupt rises with the flag, not a cycle late
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_next & mask_reg);
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign irq = irq_reg;
endmodule : lsp_serial_port

// ****************************************
// two flip-flop synchroniser for pins from outside the mclk domain
// ****************************************
module lsp_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // only the second stage is read, so a metastable first stage never spreads
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule : lsp_sync2

// File: test/lsp_serial_port_properties.sv
// pin level assertions of the serial shift port
`timescale 1ns/1ps
module lsp_serial_port_properties (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic shift_clk,
    input wire logic latch_pulse,
    input wire logic serial_out,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // shift clock high phase is 4 cycles, so a move always follows a sampled high
    property p_out_edge; $changed(serial_out) |-> $past(shift_clk); endproperty
    a_out_edge: assert property (p_out_edge) else $error("serial out moved off shift");
    property p_quiet; !shift_clk [*5] |-> $stable(serial_out); endproperty
    a_quiet: assert property (p_quiet) else $error("serial out moved while idle");
    property p_latch; $rose(latch_pulse) |=> $stable(serial_out) [*3]; endproperty
    a_latch: assert property (p_latch) else $error("latch moved serial out");
    property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("no answer after one wait state");
    property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one: assert property (p_one) else $error("answer held too long");
endmodule : lsp_serial_port_properties

// File: test/lsp_host_model.sv
// host controller driving shift clock, data and latch pins
`timescale 1ns/1ps
module lsp_host_model (
    input wire logic mclk,
    output logic shift_clk = 1'b0,
    output logic serial_in = 1'b0,
    output logic latch_pulse = 1'b0
);
    // one 400 ns shift, data set 150 ns before the rise and held 200 ns after
    task automatic shift(input logic b);
        serial_in <= b;
        repeat (3) @(posedge mclk);
        shift_clk <= 1'b1;
        repeat (4) @(posedge mclk);
        shift_clk <= 1'b0;
        serial_in <= ~b; // released data shows the inverse, never a stale copy
        @(posedge mclk);
    endtask : shift
    task automatic latch();
        latch_pulse <= 1'b1;
        repeat (4) @(posedge mclk);
        latch_pulse <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : latch
endmodule : lsp_host_model

// File: test/tb_top.sv
// self checking bench of the serial shift port
`timescale 1ns/1ps
module tb_top import lsp_pkg::*;;
    logic mclk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic shift_clk, serial_in, latch_pulse, serial_out, irq, avs_waitrequest;
    logic [4:0] flags = 5'h00;
    logic [7:0] avs_address = 8'h00;
    lsp_word_t avs_writedata = 32'h0000_0000, avs_readdata, rd, lfsr = 32'haf45_00f3;
    int err_count = 0, n_tests = 0, cyc = 0;
    bit q[$];
    lsp_serial_port DUT (.mclk(mclk), .nrst(nrst), .shift_clk(shift_clk),
        .serial_in(serial_in), .latch_pulse(latch_pulse), .led_open_flag(flags[0]),
        .led_short_flag(flags[1]), .output_leakage_flag(flags[2]),
        .thermal_error_flag(flags[3]), .reference_pin_short_flag(flags[4]),
        .serial_out(serial_out), .irq(irq), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    lsp_host_model HOST (.mclk(mclk), .shift_clk(shift_clk), .serial_in(serial_in),
        .latch_pulse(latch_pulse));
    initial forever #25 mclk = ~mclk;
    always @(posedge mclk) if (++cyc == 6000) begin err_count++; results(); end
    function automatic lsp_word_t rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task automatic chk(input lsp_word_t got, input lsp_word_t exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input lsp_word_t d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic shift(input logic b);
        HOST.shift(b);
        q.push_back(b);
        void'(q.pop_front());
        chk(32'(serial_out), 32'(q[0]));
    endtask : shift
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    initial begin
        repeat (257) q.push_back(1'b0);
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        bus(1'b1, 8'h04, 32'h0000_0002);
        repeat (260) shift(1'(rnd()));
        bus(1'b0, 8'h00, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
        chk(32'(irq), 32'h0000_0000);
        flags <= 5'(rnd());
        repeat (4) @(posedge mclk);
        HOST.latch();
        foreach (q[i]) q[i] = (i > 251) ? flags[256 - i] : 1'b0;
        chk(32'(irq), 32'h0000_0001);
        bus(1'b0, 8'h08, 32'h0000_0000);
        chk(rd, {27'h000_0000, flags});
        repeat (5) shift(1'(rnd()));
        bus(1'b0, 8'h0C, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
        repeat (252) shift(1'(rnd()));
        bus(1'b1, 8'h00, 32'h0000_0007);
        repeat (2) @(posedge mclk);
        chk(32'(irq), 32'h0000_0000);
        bus(1'b0, 8'h20, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        results();
    end
endmodule : tb_top
bind lsp_serial_port lsp_serial_port_properties CHK (.mclk(mclk), .nrst(nrst),
    .shift_clk(shift_clk), .latch_pulse(latch_pulse), .serial_out(serial_out),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
